/* File: include/devctl_pkg.sv */
/*
  Constants for the device control and status configuration dword.
  Assumes a configuration access port at dword granularity with byte enables.
*/
// Operation
// RULE1: Bit 0 enables correctable error reporting.
// RULE2: Bit 1 enables non-fatal error reporting.
// RULE3: Bit 2 enables fatal error reporting.
// RULE4: Bit 3 enables unsupported request reporting.
// RULE5: Enable defaults loadable over SMBus or EEPROM.
// RULE6: Bits 7:5 hold payload limit, reset 000b.
// RULE7: Oversized payload writes clamp to capability code.
// RULE8: Capability code means 256 bytes, reset 001b.
// RULE9: Bits 8, 9, 11, 21 read zero.
// RULE10: Bit 10 read-only aux enable, loadable default.
// RULE11: Bits 16, 17 log correctable, non-fatal errors.
// RULE12: Bits 18, 19 log fatal, unsupported request errors.
// RULE13: Flags log regardless of reporting enables.
// RULE14: Bit 20 reads aux power presence, reset 1.
// RULE15: Reserved bits zero; detection beats write-one clear.
// RULE16: Writing zero keeps flags; aux flag unaffected.
package devctl_pkg;
    localparam logic [7:0] DEV_CTRL_STATUS_OFFSET = 8'hE8;
    localparam int BIT_COR_EN = 0;
    localparam int BIT_NF_EN = 1;
    localparam int BIT_FAT_EN = 2;
    localparam int BIT_UR_EN = 3;
    localparam int BIT_RELAX_ORD = 4;
    localparam int PAYLOAD_LSB = 5;
    localparam int PAYLOAD_MSB = 7;
    localparam int BIT_AUX_PM_EN = 10;
    localparam int ERR_LSB = 16;
    localparam int BIT_AUX_DET = 20;
    localparam logic [3:0] ERR_EN_RESET = 4'h0;
    localparam logic RELAX_ORD_RESET = 1'b1;
    localparam logic [2:0] PAYLOAD_RESET = 3'h0;
    localparam logic [2:0] PAYLOAD_CAP_RESET = 3'h1;
    localparam logic AUX_PM_EN_RESET = 1'b0;
    localparam logic AUX_DET_RESET = 1'b1;
endpackage

/* File: core/payload_clamp.sv */
/*
  Clamps a written payload limit code to the supported capability code.
  Assumes both codes use the standard size encoding.
*/
`timescale 1ns/1ns
module payload_clamp (
    input wire logic [2:0] wr_code,
    input wire logic [2:0] cap_code,
    output logic [2:0] stored_code
);
    // Larger codes than the capability would advertise sizes the buffers cannot hold.
    assign stored_code = (wr_code > cap_code) ? cap_code : wr_code; // [RULE7]
endmodule // payload_clamp

/* File: core/error_flags.sv */
/*
  Four write-one-to-clear error detected flags.
  Assumes detect pulses and clear masks are synchronous to clock.
*/
`timescale 1ns/1ns
module error_flags (
    input wire logic clock,
    input wire logic srst,
    input wire logic [3:0] detect,
    input wire logic [3:0] clear,
    output logic [3:0] flags_q
);
    typedef struct packed {
        logic [3:0] flags;
    } state_t;
    state_t s_q;
    state_t s_d;
    always_comb begin
        s_d = s_q;
        // Detection is ORed after the clear so an error in a clearing cycle survives.
        s_d.flags = (s_q.flags & ~clear) | detect; // [RULE11] [RULE12] [RULE13] [RULE15] [RULE16]
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign flags_q = s_q.flags;
endmodule // error_flags

/* File: core/dev_ctrl_status.sv */
/*
  Device control and device status configuration dword.
  Assumes a single-cycle configuration write and a combinational read path,
  and preload strobes from the SMBus or EEPROM loader.
*/
`timescale 1ns/1ns
module dev_ctrl_status (
    input wire logic clock,
    input wire logic srst,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    input wire logic load_valid,
    input wire logic [3:0] load_err_en,
    input wire logic load_aux_pm_en,
    input wire logic [2:0] load_payload_cap,
    input wire logic [3:0] err_detect,
    input wire logic aux_power_present,
    output logic [3:0] err_report_en,
    output logic relaxed_order_en,
    output logic [2:0] payload_limit,
    output logic [2:0] payload_cap,
    output logic aux_pm_en
);
    typedef struct packed {
        logic [3:0] err_en;
        logic relax;
        logic [2:0] payload;
        logic [2:0] cap;
        logic aux_pm;
        logic aux_det;
    } state_t;
    state_t s_q;
    state_t s_d;
    logic hit;
    logic [2:0] clamped;
    logic [3:0] err_clear;
    logic [3:0] err_flags;

    assign hit = cfg_wr && (cfg_addr == devctl_pkg::DEV_CTRL_STATUS_OFFSET);

    payload_clamp u_clamp (
        .wr_code(cfg_wdata[devctl_pkg::PAYLOAD_MSB:devctl_pkg::PAYLOAD_LSB]),
        .cap_code(s_q.cap),
        .stored_code(clamped)
    );

    assign err_clear = (hit && cfg_be[2]) ? cfg_wdata[19:16] : 4'h0; // [RULE11] [RULE12]

    error_flags u_flags (
        .clock(clock),
        .srst(srst),
        .detect(err_detect),
        .clear(err_clear),
        .flags_q(err_flags)
    );

    always_comb begin
        s_d = s_q;
        // Aux presence follows the pin; status writes never touch it.
        s_d.aux_det = aux_power_present; // [RULE14] [RULE16]
        if (load_valid) begin
            // The loader runs before enumeration, so it simply overrides.
            s_d.err_en = load_err_en; // [RULE5]
            s_d.aux_pm = load_aux_pm_en; // [RULE5] [RULE10]
            s_d.cap = load_payload_cap; // [RULE8]
        end else if (hit) begin
            if (cfg_be[0]) begin
                s_d.err_en = cfg_wdata[3:0]; // [RULE1] [RULE2] [RULE3] [RULE4]
                s_d.relax = cfg_wdata[devctl_pkg::BIT_RELAX_ORD];
                s_d.payload = clamped; // [RULE6] [RULE7]
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s_q.err_en <= devctl_pkg::ERR_EN_RESET;
            s_q.relax <= devctl_pkg::RELAX_ORD_RESET;
            s_q.payload <= devctl_pkg::PAYLOAD_RESET; // [RULE6]
            s_q.cap <= devctl_pkg::PAYLOAD_CAP_RESET; // [RULE8]
            s_q.aux_pm <= devctl_pkg::AUX_PM_EN_RESET; // [RULE10]
            s_q.aux_det <= devctl_pkg::AUX_DET_RESET; // [RULE14]
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        cfg_rdata = 32'h0; // [RULE9] [RULE15]
        if (cfg_addr == devctl_pkg::DEV_CTRL_STATUS_OFFSET) begin
            cfg_rdata[3:0] = s_q.err_en;
            cfg_rdata[devctl_pkg::BIT_RELAX_ORD] = s_q.relax;
            cfg_rdata[devctl_pkg::PAYLOAD_MSB:devctl_pkg::PAYLOAD_LSB] = s_q.payload;
            cfg_rdata[devctl_pkg::BIT_AUX_PM_EN] = s_q.aux_pm; // [RULE10]
            cfg_rdata[19:16] = err_flags; // [RULE11] [RULE12]
            cfg_rdata[devctl_pkg::BIT_AUX_DET] = s_q.aux_det; // [RULE14]
        end
    end

    assign err_report_en = s_q.err_en;
    assign relaxed_order_en = s_q.relax;
    assign payload_limit = s_q.payload;
    assign payload_cap = s_q.cap;
    assign aux_pm_en = s_q.aux_pm;
endmodule // dev_ctrl_status

/* File: sim/cfg_host.sv */
/* Host configuration writer model.
   Assumes calls start just after a falling edge of clock. */
`timescale 1ns/1ns
module cfg_host (
    input wire logic clock,
    output logic cfg_wr = 1'b0,
    output logic [3:0] cfg_be = 4'h0,
    output logic [31:0] cfg_wdata = 32'h0
);
    task automatic wr(input logic [3:0] be, input logic [31:0] d);
        cfg_be = be;
        cfg_wdata = d;
        cfg_wr = 1'b1;
        @(negedge clock);
        cfg_wr = 1'b0;
        // One idle cycle keeps back-to-back calls from lowering and raising the strobe at once.
        @(negedge clock);
    endtask
endmodule // cfg_host

/* File: sim/devctl_sva.sv */
/* Checker for the device control and status dword.
   Assumes it is bound to dev_ctrl_status by port name. */
`timescale 1ns/1ns
module devctl_sva (
    input wire logic clock, srst, cfg_wr, load_valid, load_aux_pm_en,
    input wire logic aux_power_present, aux_pm_en,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be, load_err_en, err_detect, err_report_en,
    input wire logic [2:0] load_payload_cap, payload_limit, payload_cap,
    input wire logic [31:0] cfg_wdata, cfg_rdata
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    sequence hit_s; cfg_addr == 8'hE8; endsequence
    sequence wr_s; hit_s ##0 cfg_wr && !load_valid; endsequence
    enables_write_a: assert property (wr_s ##0 cfg_be[0] |=>
        err_report_en == $past(cfg_wdata[3:0])) else $error("enables");
    payload_clamp_a: assert property (wr_s ##0 cfg_be[0] |=> payload_limit ==
        ($past(cfg_wdata[7:5]) > payload_cap ? payload_cap : $past(cfg_wdata[7:5])))
        else $error("payload");
    loader_apply_a: assert property (load_valid |=> err_report_en == $past(load_err_en) &&
        aux_pm_en == $past(load_aux_pm_en) && payload_cap == $past(load_payload_cap))
        else $error("loader");
    ro_zero_a: assert property ((cfg_rdata & 32'hFFE0_FB00) == 32'h0)
        else $error("ro bits");
    flag_set_a: assert property (|err_detect ##1 hit_s |->
        (cfg_rdata[19:16] & $past(err_detect)) == $past(err_detect)) else $error("set");
    flag_clear_a: assert property (wr_s ##0 cfg_be[2] && cfg_wdata[16] &&
        !err_detect[0] ##1 hit_s |-> !cfg_rdata[16]) else $error("clear");
    flag_hold_a: assert property (hit_s ##0 !cfg_wr && err_detect == 4'h0 ##1 hit_s |->
        $stable(cfg_rdata[19:16])) else $error("hold");
    aux_follow_a: assert property (hit_s ##1 hit_s |->
        cfg_rdata[20] == $past(aux_power_present)) else $error("aux");
endmodule // devctl_sva
bind dev_ctrl_status devctl_sva sva (.*);

/* File: sim/pcie_device_ctrl_status_bench.sv */
/* Bench for the device control and status dword.
   Assumes the host model writes; the bench drives loader and detectors. */
`timescale 1ns/1ns
module pcie_device_ctrl_status_bench;
    logic clock = 1'b0, srst = 1'b1, load_valid = 1'b0, load_aux_pm_en = 1'b0;
    logic aux_power_present = 1'b1, relaxed_order_en, aux_pm_en, cfg_wr;
    logic [7:0] cfg_addr = 8'hE8;
    logic [3:0] load_err_en = 4'h0, err_detect = 4'h0, cfg_be, err_report_en;
    logic [2:0] load_payload_cap = 3'h0, payload_limit, payload_cap;
    logic [31:0] cfg_wdata, cfg_rdata;
    int err_total = 0, samples_checked = 0;
    cfg_host host (.clock(clock), .cfg_wr(cfg_wr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
    dev_ctrl_status dut (.*);
    initial forever #5 clock = ~clock;
    task automatic chk(input string n, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clock);
        srst = 1'b0;
        @(negedge clock);
        chk("reset", cfg_rdata, 32'h0010_0010);
        chk("relax0", relaxed_order_en, 1'b1);
        chk("auxen0", aux_pm_en, 1'b0);
        chk("cap", payload_cap, 3'h1);
        host.wr(4'hF, 32'hFFFF_FFEF);
        chk("ro", cfg_rdata, 32'h0010_002F);
        for (int i = 0; i < 4; i++) begin
            host.wr(4'h1, (32'h1 << i) | (i << 5));
            chk("en", err_report_en, 4'h1 << i);
            chk("mps", payload_limit, (i > 1) ? 3'h1 : 3'(i));
        end
        {load_valid, load_err_en, load_aux_pm_en, load_payload_cap} = 9'h1AD;
        @(negedge clock);
        load_valid = 1'b0;
        chk("ld", err_report_en, 4'hA);
        chk("ldcap", payload_cap, 3'h5);
        chk("ldaux", aux_pm_en, 1'b1);
        host.wr(4'hF, 32'h0000_00C0);
        chk("ldw", cfg_rdata, 32'h0010_04A0);
        chk("relax", relaxed_order_en, 1'b0);
        cfg_addr = 8'hE4;
        host.wr(4'h1, 32'h0000_000F);
        chk("miss", cfg_rdata, 32'h0);
        cfg_addr = 8'hE8;
        @(negedge clock);
        chk("missw", err_report_en, 4'h0);
        err_detect = 4'hF;
        @(negedge clock);
        err_detect = 4'h0;
        host.wr(4'h4, 32'h0);
        chk("keep", cfg_rdata[19:16], 4'hF);
        err_detect = 4'h1;
        host.wr(4'h4, 32'h0001_0000);
        err_detect = 4'h0;
        chk("race", cfg_rdata[19:16], 4'hF);
        host.wr(4'h4, 32'h003F_0000);
        chk("clr", cfg_rdata, 32'h0010_04A0);
        aux_power_present = 1'b0;
        @(negedge clock);
        chk("aux", cfg_rdata[20], 1'b0);
        tally_and_finish();
    end
endmodule // pcie_device_ctrl_status_bench
